// ---- bench/spi_link_properties.sv ----
// Concurrent checks on the serial link between the port core and its peer
`timescale 1ns/100ps
module spi_link_properties (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Drive enables of each end
   input wire logic dev_sck_oe,
   input wire logic dev_sdo_oe,
   input wire logic dev_ss_oe,
   input wire logic peer_sck_oe,
   input wire logic peer_sdo_oe,
   input wire logic peer_ss_oe,
   // Resolved wires
   input wire logic sck,
   input wire logic ss_n
);
   logic       sck_q;
   logic [7:0] edges;

   // ==========================================================
   // Clock edges counted inside one selected frame
   always_ff @(posedge aclk)
      sck_q <= sck;

   always_ff @(posedge aclk)
      if (!aresetn || ss_n)
         edges <= 8'h00;
      else if (sck != sck_q)
         edges <= edges + 8'h01;

   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ==========================================================
   // Frame steps
   sequence frame_open;
      $fell(ss_n);
   endsequence

   sequence frame_close;
      $rose(ss_n);
   endsequence

   sequence sck_quiet;
      $stable(sck) [*2];
   endsequence

   one_sck_drv_a: assert property (!(dev_sck_oe && peer_sck_oe))
      else $error("sck driven from both ends");
   one_ss_drv_a: assert property (!(dev_ss_oe && peer_ss_oe))
      else $error("select driven from both ends");
   master_pins_a: assert property (dev_sck_oe == dev_ss_oe)
      else $error("master clock and select enables differ");
   dev_release_a: assert property (ss_n && !dev_sck_oe |-> !dev_sdo_oe)
      else $error("unselected core drives data");
   peer_release_a: assert property (ss_n && !peer_sck_oe |-> !peer_sdo_oe)
      else $error("unselected peer drives data");
   frame_bytes_a: assert property (frame_close |-> edges[3:0] == 4'h0 && edges != 8'h00)
      else $error("frame not whole bytes");
   select_lead_a: assert property (frame_open |-> sck_quiet)
      else $error("clock moved as select fell");
   deselect_quiet_a: assert property (frame_close |-> $stable(sck))
      else $error("clock moved as select rose");
   sck_half_min_a: assert property ($changed(sck) |=> $stable(sck))
      else $error("sck half period below two clocks");
endmodule : spi_link_properties

// ---- bench/sync_serial_port_tb.sv ----
// Bench: port core and far-end peer joined over the serial link
`timescale 1ns/100ps
module sync_serial_port_tb;
   import spi_port_pkg::*;

   typedef struct packed {
      logic [3:0] mode;
      logic       cpol;
      logic       cke;
      logic [7:0] db;
      logic [7:0] pb;
   } xfer_row_t;

   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, tx_data = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        timer_tick = 1'b0, as_master = 1'b0, cpol = 1'b0, cke = 1'b0, start = 1'b0;
   logic [1:0]  tcnt = 2'h0;
   logic        awready, wready, bvalid, arready, rvalid, done, busy;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic [7:0]  rx_data;
   int          n_mismatch = 0, n_checks = 0, cyc = 0;
   xfer_row_t   rows [5] = '{'{MODE_DIV4, 1'b0, 1'b0, 8'ha5, 8'h5a},
                             '{MODE_DIV16, 1'b1, 1'b0, 8'h81, 8'h7e},
                             '{MODE_DIV64, 1'b0, 1'b1, 8'hff, 8'h00},
                             '{MODE_TIMER, 1'b1, 1'b1, 8'h00, 8'hff},
                             '{MODE_RELOAD, 1'b0, 1'b1, 8'h3c, 8'hc3}};

   spi_link_if spi_link_if_inst ();

   sync_serial_port sync_serial_port_inst (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready),
      .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .timer_tick(timer_tick), .link(spi_link_if_inst));

   spi_peer_end spi_peer_end_inst (.aclk(aclk), .aresetn(aresetn), .as_master(as_master),
      .cpol(cpol), .cke(cke), .start(start), .keep_select(1'b0), .tx_data(tx_data),
      .rx_data(rx_data), .done(done), .busy(busy), .link(spi_link_if_inst));

   spi_link_properties spi_link_properties_inst (.aclk(aclk), .aresetn(aresetn),
      .dev_sck_oe(spi_link_if_inst.dev_sck_oe), .dev_sdo_oe(spi_link_if_inst.dev_sdo_oe),
      .dev_ss_oe(spi_link_if_inst.dev_ss_oe), .peer_sck_oe(spi_link_if_inst.peer_sck_oe),
      .peer_sdo_oe(spi_link_if_inst.peer_sdo_oe), .peer_ss_oe(spi_link_if_inst.peer_ss_oe),
      .sck(spi_link_if_inst.sck), .ss_n(spi_link_if_inst.ss_n));

   always #10 aclk = ~aclk;

   // ==========================================================
   // Timer pulse every third clock, slow enough for the link
   always @(posedge aclk)
   begin
      tcnt       <= (tcnt == 2'h2) ? 2'h0 : tcnt + 2'h1;
      timer_tick <= (tcnt == 2'h2);
   end

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         n_mismatch++;
         finish_test();
      end
   end

   // ==========================================================
   // Comparison and bus tasks
   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t data %h expected %h", $time, got, exp);
      end
   endtask : chk_data

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t response %h expected %h", $time, got, exp);
      end
   endtask : chk_resp

   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk_resp(r, RESP_OKAY);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(a, d, r);
      chk_data(d, exp);
      chk_resp(r, RESP_OKAY);
   endtask : rd_chk

   // Polls the done flag; bounded so a dead link cannot hang here
   task automatic wait_done();
      logic [31:0] d;
      logic [1:0]  r;
      d = 32'h0;
      for (int i = 0; i < 400 && d[FLAGS_DONE] !== 1'b1; i++)
         axi_rd(ADDR_FLAGS, d, r);
      chk_data({31'h0, d[FLAGS_DONE]}, 32'h1);
   endtask : wait_done

   task automatic peer_load(input logic [7:0] pb);
      tx_data <= pb;
      start   <= 1'b1;
      @(posedge aclk);
      start   <= 1'b0;
   endtask : peer_load

   task automatic master_xfer(input logic [7:0] db, input logic [7:0] pb, input logic k);
      peer_load(pb);
      wr(ADDR_FLAGS, 32'h2);
      wr(ADDR_BUF, {24'h0, db});
      wait_done();
      wr(ADDR_FLAGS, 32'h1);
      rd_chk(ADDR_STAT, {24'h0, 1'b0, k, 6'h1});
      rd_chk(ADDR_BUF, {24'h0, pb});
      rd_chk(ADDR_STAT, {24'h0, 1'b0, k, 6'h0});
      chk_data({24'h0, rx_data}, {24'h0, db});
   endtask : master_xfer

   task automatic finish_test();
      $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   // ==========================================================
   // Main sequence
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      for (int a = 0; a < 6; a++)
         rd_chk(8'(a * 4), 32'h0);
      wr(ADDR_STAT, 32'hff);
      rd_chk(ADDR_STAT, 32'hc0);
      wr(ADDR_CON1, 32'h4f);
      rd_chk(ADDR_CON1, 32'h4f);
      wr(ADDR_CON3, 32'ha5);
      rd_chk(ADDR_CON3, 32'ha5);
      axi_wr(8'h18, 32'hff, r);
      chk_resp(r, RESP_SLVERR);
      axi_rd(8'h18, d, r);
      chk_data(d, 32'h0);
      chk_resp(r, RESP_SLVERR);
      wr(ADDR_RELOAD, 32'h1);
      rd_chk(ADDR_RELOAD, 32'h1);
      foreach (rows[i])
      begin
         cpol <= rows[i].cpol;
         cke  <= rows[i].cke;
         wr(ADDR_STAT, {24'h0, 1'b0, rows[i].cke, 6'h0});
         wr(ADDR_CON1, {27'h1, rows[i].cpol, rows[i].mode});
         master_xfer(rows[i].db, rows[i].pb, rows[i].cke);
      end
      // Second write lands mid-byte and must be dropped
      peer_load(8'h66);
      wr(ADDR_FLAGS, 32'h2);
      wr(ADDR_BUF, 32'h11);
      wr(ADDR_BUF, 32'h22);
      rd_chk(ADDR_CON1, 32'haa);
      wait_done();
      rd_chk(ADDR_BUF, 32'h66);
      chk_data({24'h0, rx_data}, 32'h11);
      wr(ADDR_CON1, 32'h2a);
      rd_chk(ADDR_CON1, 32'h2a);
      wr(ADDR_FLAGS, 32'h1);
      // Core as selected slave, peer drives the clock
      wr(ADDR_STAT, 32'h40);
      wr(ADDR_CON1, 32'h24);
      wr(ADDR_BUF, 32'h3c);
      as_master <= 1'b1;
      peer_load(8'hc3);
      for (int i = 0; i < 500 && done !== 1'b1; i++)
         @(posedge aclk);
      chk_data({24'h0, rx_data}, 32'h3c);
      wait_done();
      rd_chk(ADDR_BUF, 32'hc3);
      rd_chk(ADDR_STAT, 32'h40);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk(ADDR_CON1, 32'h0);
      finish_test();
   end
endmodule : sync_serial_port_tb

// ---- src/spi_link_if.sv ----
// Serial link between the port core and its far-end peer
`timescale 1ns/100ps
interface spi_link_if;
   logic dev_sck_o;
   logic dev_sck_oe;
   logic dev_sdo_o;
   logic dev_sdo_oe;
   logic dev_ss_o;
   logic dev_ss_oe;
   logic peer_sck_o;
   logic peer_sck_oe;
   logic peer_sdo_o;
   logic peer_sdo_oe;
   logic peer_ss_o;
   logic peer_ss_oe;
   logic sck;
   logic dev_sdi;
   logic peer_sdi;
   logic ss_n;

   // Undriven lines settle at pull levels
   assign sck      = dev_sck_oe ? dev_sck_o : (peer_sck_oe ? peer_sck_o : 1'b0);
   assign ss_n     = dev_ss_oe ? dev_ss_o : (peer_ss_oe ? peer_ss_o : 1'b1);
   assign dev_sdi  = peer_sdo_oe ? peer_sdo_o : 1'b1;
   assign peer_sdi = dev_sdo_oe ? dev_sdo_o : 1'b1;

   modport dev_end (
      output dev_sck_o, dev_sck_oe, dev_sdo_o, dev_sdo_oe, dev_ss_o, dev_ss_oe,
      input  sck, dev_sdi, ss_n
   );
   modport peer_end (
      output peer_sck_o, peer_sck_oe, peer_sdo_o, peer_sdo_oe, peer_ss_o, peer_ss_oe,
      input  sck, peer_sdi, ss_n
   );
endinterface : spi_link_if

// ---- src/spi_peer_end.sv ----
// Far-end serial partner: master or slave, one byte per start
`timescale 1ns/100ps
module spi_peer_end
   import spi_port_pkg::*;
(
   // Clock and reset
   input  wire logic       aclk,
   input  wire logic       aresetn,
   // User side
   input  wire logic       as_master,
   input  wire logic       cpol,
   input  wire logic       cke,
   input  wire logic       start,
   input  wire logic       keep_select,
   input  wire logic [7:0] tx_data,
   output logic      [7:0] rx_data,
   output logic            done,
   output logic            busy,
   // Link
   spi_link_if.peer_end    link
);
   xfer_state_t state_reg;
   logic [7:0]  sr_reg;
   logic [3:0]  cnt_reg;
   logic [9:0]  div_reg;
   logic        act_reg;
   logic        sdo_reg;
   logic        ss_n_reg;
   logic        prev_reg;
   logic [7:0]  rx_reg;
   logic        done_reg;

   wire       act_in   = link.sck ^ cpol;
   wire       selected = ~as_master & ~link.ss_n;
   wire       tick     = (state_reg == ST_SHIFT) && (div_reg == HALF_PEER - DIV_ONE);
   wire       lead_ev  = as_master ? (tick & ~act_reg) : (selected & act_in & ~prev_reg);
   wire       trail_ev = as_master ? (tick & act_reg) : (selected & ~act_in & prev_reg);
   wire       cap_ev   = cke ? lead_ev : trail_ev;
   wire       lau_ev   = cke ? trail_ev : lead_ev;
   wire [3:0] cnt_aft  = cnt_reg + {3'h0, cap_ev};
   wire       finish   = as_master ? (trail_ev && cnt_aft == BYTE_BITS)
                                   : (cap_ev && cnt_aft == BYTE_BITS);
   wire       load     = start && state_reg == ST_IDLE && cnt_reg == 4'h0;

   assign busy             = (state_reg != ST_IDLE) || (cnt_reg != 4'h0);
   assign rx_data          = rx_reg;
   assign done             = done_reg;
   assign link.peer_sck_o  = act_reg ^ cpol;
   assign link.peer_sck_oe = as_master;                  // (R5)
   assign link.peer_ss_o   = ss_n_reg;
   assign link.peer_ss_oe  = as_master;                  // (R9)
   assign link.peer_sdo_o  = sdo_reg;
   assign link.peer_sdo_oe = as_master | selected;

   // ==========================================================
   // Shift engine
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ST_IDLE;
         sr_reg    <= RST_BYTE;
         cnt_reg   <= 4'h0;
         div_reg   <= 10'h000;
         act_reg   <= 1'b0;
         sdo_reg   <= 1'b0;
         ss_n_reg  <= 1'b1;
         prev_reg  <= 1'b0;
         rx_reg    <= RST_BYTE;
         done_reg  <= 1'b0;
      end
      else
      begin
         prev_reg <= act_in;
         done_reg <= 1'b0;
         div_reg  <= (tick || state_reg != ST_SHIFT) ? 10'h000 : div_reg + DIV_ONE;
         if (tick)
            act_reg <= ~act_reg;
         if (!as_master && link.ss_n)
            cnt_reg <= 4'h0;
         if (load)
         begin
            sr_reg  <= tx_data;                          // (R10)
            sdo_reg <= tx_data[7];                       // (R5)
            if (as_master)
            begin
               state_reg <= ST_SHIFT;
               ss_n_reg  <= 1'b0;
            end
         end
         else if (state_reg == ST_DONE)
         begin
            rx_reg    <= sr_reg;                         // (R4)
            done_reg  <= 1'b1;
            state_reg <= ST_IDLE;
            if (as_master && !keep_select)
               ss_n_reg <= 1'b1;                         // (R7)
         end
         else
         begin
            if (cap_ev)
            begin
               sr_reg  <= {sr_reg[6:0], link.peer_sdi};  // (R1) (R3)
               cnt_reg <= cnt_aft;
            end
            if (lau_ev)
               sdo_reg <= sr_reg[7];                     // (R2)
            if (finish)
            begin
               cnt_reg   <= 4'h0;
               state_reg <= ST_DONE;
            end
         end
      end
   end
endmodule : spi_peer_end

// ---- src/spi_port_pkg.sv ----
// Shared constants and types for the serial port core and its far-end peer
package spi_port_pkg;

   // ==========================================================
   // Register map (byte addresses, one aligned word each)
   localparam logic [7:0] ADDR_STAT   = 8'h00;
   localparam logic [7:0] ADDR_CON1   = 8'h04;
   localparam logic [7:0] ADDR_CON3   = 8'h08;
   localparam logic [7:0] ADDR_BUF    = 8'h0c;
   localparam logic [7:0] ADDR_RELOAD = 8'h10;
   localparam logic [7:0] ADDR_FLAGS  = 8'h14;

   // ==========================================================
   // Field positions
   localparam int STAT_SMP   = 7;
   localparam int STAT_CKE   = 6;
   localparam int STAT_BF    = 0;
   localparam int CON1_WRITE_COLLISION_FLAG  = 7;
   localparam int CON1_EN    = 5;
   localparam int CON1_CKP   = 4;
   localparam int FLAGS_DONE = 0;
   localparam int FLAGS_SEL  = 1;

   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_CFG  = 2'h0;

   // ==========================================================
   // Mode field of control register one
   localparam logic [3:0] MODE_DIV4    = 4'h0;
   localparam logic [3:0] MODE_DIV16   = 4'h1;
   localparam logic [3:0] MODE_DIV64   = 4'h2;
   localparam logic [3:0] MODE_TIMER   = 4'h3;
   localparam logic [3:0] MODE_SLV_SS  = 4'h4;
   localparam logic [3:0] MODE_SLV_NSS = 4'h5;
   localparam logic [3:0] MODE_RELOAD  = 4'ha;

   // ==========================================================
   // Serial clock half periods in system clocks
   localparam logic [9:0] HALF_DIV4  = 10'h002;
   localparam logic [9:0] HALF_DIV16 = 10'h008;
   localparam logic [9:0] HALF_DIV64 = 10'h020;
   localparam logic [9:0] HALF_PEER  = 10'h004;
   localparam logic [9:0] DIV_ONE    = 10'h001;
   localparam logic [3:0] BYTE_BITS  = 4'h8;

   // ==========================================================
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE  = 2'b11
   } xfer_state_t;

endpackage : spi_port_pkg

// ---- src/sync_serial_port.sv ----
// Synchronous serial port core, SPI mode, with AXI4-Lite register access
//
// What this block does
// (R1) Eight-bit shift register, MSb out, LSb in
// (R2) Drive on one clock edge, capture opposite
// (R3) One bit each way per clock cycle
// (R4) After eight bits both registers exchanged
// (R5) Master starts clock and sends MSb first
// (R6) Both ends use same clock idle polarity
// (R7) Master stops clock; select follows FLAGS_SEL and is released by a software write, by reset or by leaving master mode
// (R8) Unselected slave ignores clock, drives nothing
// (R9) Master drives one select, one active
// (R10) Further bytes reload shift register, shifting continues
// (R11) Full byte goes to buffer, flag set
// (R12) Buffer write loads buffer and shift register
// (R13) Shift register reached only through buffer
// (R14) Status: low six bits read-only, top two writable
// (R15) Control register one fully readable and writable
// (R16) Reload mode takes rate from reload register
// (R17) Each instance independent, own registers and pins
// (R18) Byte load sets full flag, read clears
// (R19) Write while shifting dropped, collision flag set
// (R20) Master rate: /4, /16, /64, timer/2, reload
// (R21) Select high in select mode: release, reset
// (R22) Bit counter cleared on reset or disable
// (R23) Master buffer write while idle starts transfer
`timescale 1ns/100ps
module sync_serial_port
   import spi_port_pkg::*;
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic      [1:0]  bresp,
   // AXI4-Lite read
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic      [31:0] rdata,
   output logic      [1:0]  rresp,
   // Timer output pulse for the timer rate
   input  wire logic        timer_tick,
   // Link
   spi_link_if.dev_end      link
);
   // All state lives here, so instances never interact (R17)
   xfer_state_t state_reg;
   logic [1:0]  cfg_reg;
   logic        bf_reg;
   logic [7:0]  con1_reg;
   logic [7:0]  con3_reg;
   logic [7:0]  buf_reg;
   logic [7:0]  sr_reg;
   logic [7:0]  reload_reg;
   logic        done_flag_reg;
   logic        sel_reg;
   logic [3:0]  cnt_reg;
   logic [9:0]  div_reg;
   logic        act_reg;
   logic        sdo_reg;
   logic        prev_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;

   // ==========================================================
   // Mode decode
   wire [3:0] mode      = con1_reg[3:0];
   wire       enabled   = con1_reg[CON1_EN];
   wire       cke       = cfg_reg[STAT_CKE - 6];
   wire       slv_mode  = (mode == MODE_SLV_SS) || (mode == MODE_SLV_NSS);
   wire       mst_mode  = (mode == MODE_DIV4) || (mode == MODE_DIV16) || (mode == MODE_DIV64)
                          || (mode == MODE_TIMER) || (mode == MODE_RELOAD);
   wire       is_master = enabled & mst_mode;
   wire       is_slave  = enabled & slv_mode;
   wire       ss_drop   = is_slave && mode == MODE_SLV_SS && link.ss_n;
   wire       selected  = is_slave & ~ss_drop;
   wire       hold_rst  = ~enabled | ss_drop;
   // Pin idle level follows the polarity bit; the peer must match it (R6)
   wire       act_in    = link.sck ^ con1_reg[CON1_CKP];

   // ==========================================================
   // Master rate generator
   wire [9:0] reload_half = {1'b0, reload_reg, 1'b0} + 10'h002;       // (R16)
   wire [9:0] half_len    = (mode == MODE_DIV16)  ? HALF_DIV16 :
                            (mode == MODE_DIV64)  ? HALF_DIV64 :
                            (mode == MODE_RELOAD) ? reload_half : HALF_DIV4;
   wire       shifting    = state_reg == ST_SHIFT;
   wire       tick        = shifting && ((mode == MODE_TIMER) ? timer_tick
                                         : (div_reg == half_len - DIV_ONE));  // (R20)

   // ==========================================================
   // Edge classification
   wire       lead_ev  = is_master ? (tick & ~act_reg) : (selected & act_in & ~prev_reg);
   wire       trail_ev = is_master ? (tick & act_reg) : (selected & ~act_in & prev_reg);
   wire       cap_ev   = cke ? lead_ev : trail_ev;
   wire       lau_ev   = cke ? trail_ev : lead_ev;
   wire [3:0] cnt_aft  = cnt_reg + {3'h0, cap_ev};
   wire       finish   = is_master ? (trail_ev && cnt_aft == BYTE_BITS)
                                   : (cap_ev && cnt_aft == BYTE_BITS);
   wire       busy     = (state_reg != ST_IDLE) || (cnt_reg != 4'h0);

   // ==========================================================
   // Bus decode
   wire       wr_go     = awvalid & wvalid & ~bvalid_reg;
   wire       wr_lane   = wr_go & wstrb[0];
   wire       wr_stat   = wr_lane && awaddr == ADDR_STAT;
   wire       wr_con1   = wr_lane && awaddr == ADDR_CON1;
   wire       wr_con3   = wr_lane && awaddr == ADDR_CON3;
   wire       wr_buf    = wr_lane && awaddr == ADDR_BUF;
   wire       wr_reload = wr_lane && awaddr == ADDR_RELOAD;
   wire       wr_flags  = wr_lane && awaddr == ADDR_FLAGS;
   wire       wr_map    = (awaddr == ADDR_STAT) || (awaddr == ADDR_CON1)
                          || (awaddr == ADDR_CON3) || (awaddr == ADDR_BUF)
                          || (awaddr == ADDR_RELOAD) || (awaddr == ADDR_FLAGS);
   wire       buf_load  = wr_buf & ~busy & enabled;
   wire       collision = wr_buf & busy;                               // (R19)
   wire       rd_go     = arvalid & ~rvalid_reg;
   wire       rd_buf    = rd_go && araddr == ADDR_BUF;
   wire       rd_map    = (araddr == ADDR_STAT) || (araddr == ADDR_CON1)
                          || (araddr == ADDR_CON3) || (araddr == ADDR_BUF)
                          || (araddr == ADDR_RELOAD) || (araddr == ADDR_FLAGS);
   wire [7:0] stat_view = {cfg_reg, 5'h00, bf_reg};                    // (R14)
   wire [7:0] flag_view = {6'h00, sel_reg, done_flag_reg};
   wire [7:0] rd_byte   = (araddr == ADDR_STAT)   ? stat_view :
                          (araddr == ADDR_CON1)   ? con1_reg :         // (R15)
                          (araddr == ADDR_CON3)   ? con3_reg :
                          (araddr == ADDR_BUF)    ? buf_reg :          // (R13)
                          (araddr == ADDR_RELOAD) ? reload_reg :
                          (araddr == ADDR_FLAGS)  ? flag_view : RST_BYTE;

   // Hardware sets win over software clears
   wire write_collision_flag_next = collision | (wr_con1 ? wdata[CON1_WRITE_COLLISION_FLAG] : con1_reg[CON1_WRITE_COLLISION_FLAG]);
   wire bf_next   = (state_reg == ST_DONE) | (bf_reg & ~rd_buf);       // (R18)
   wire done_next = (state_reg == ST_DONE)
                    | (done_flag_reg & ~(wr_flags & wdata[FLAGS_DONE]));   // (R11)

   assign awready = wr_go;
   assign wready  = wr_go;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign arready = rd_go;
   assign rvalid  = rvalid_reg;
   assign rdata   = rdata_reg;
   assign rresp   = rresp_reg;

   // ==========================================================
   // Pins
   assign link.dev_sck_o  = act_reg ^ con1_reg[CON1_CKP];
   assign link.dev_sck_oe = is_master;
   assign link.dev_ss_o   = ~sel_reg;
   assign link.dev_ss_oe  = is_master;
   assign link.dev_sdo_o  = sdo_reg;
   assign link.dev_sdo_oe = is_master | selected;                      // (R8) (R21)

   // ==========================================================
   // Registers and bus answers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cfg_reg       <= RST_CFG;
         bf_reg        <= 1'b0;
         con1_reg      <= RST_BYTE;
         con3_reg      <= RST_BYTE;
         reload_reg    <= RST_BYTE;
         done_flag_reg <= 1'b0;
         sel_reg       <= 1'b0;
         bvalid_reg    <= 1'b0;
         bresp_reg     <= RESP_OKAY;
         rvalid_reg    <= 1'b0;
         rdata_reg     <= 32'h0000_0000;
         rresp_reg     <= RESP_OKAY;
      end
      else
      begin
         if (wr_stat)
            cfg_reg <= wdata[STAT_SMP:STAT_CKE];                       // (R14)
         if (wr_con1)
            con1_reg[6:0] <= wdata[6:0];                               // (R15)
         con1_reg[CON1_WRITE_COLLISION_FLAG] <= write_collision_flag_next;                             // (R19)
         if (wr_con3)
            con3_reg <= wdata[7:0];
         if (wr_reload)
            reload_reg <= wdata[7:0];
         if (wr_flags)
            sel_reg <= wdata[FLAGS_SEL];
         bf_reg        <= bf_next;
         done_flag_reg <= done_next;
         if (wr_go)
         begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bready)
            bvalid_reg <= 1'b0;
         if (rd_go)
         begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= {24'h00_0000, rd_byte};
            rresp_reg  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rready)
            rvalid_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Shift engine
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state_reg <= ST_IDLE;
         buf_reg   <= RST_BYTE;
         sr_reg    <= RST_BYTE;
         cnt_reg   <= 4'h0;                                            // (R22)
         div_reg   <= 10'h000;
         act_reg   <= 1'b0;
         sdo_reg   <= 1'b0;
         prev_reg  <= 1'b0;
      end
      else
      begin
         prev_reg <= act_in;
         div_reg  <= (tick || !shifting) ? 10'h000 : div_reg + DIV_ONE;
         // Preload must work while deselected; only idle loads reach here
         if (buf_load)
         begin
            buf_reg <= wdata[7:0];                                     // (R12)
            sr_reg  <= wdata[7:0];                                     // (R10)
            sdo_reg <= wdata[7];
            if (is_master)
               state_reg <= ST_SHIFT;                                  // (R23)
         end
         else if (hold_rst)
         begin
            state_reg <= ST_IDLE;                                      // (R21)
            cnt_reg   <= 4'h0;                                         // (R22)
            act_reg   <= 1'b0;
         end
         else if (state_reg == ST_DONE)
         begin
            buf_reg   <= sr_reg;                                       // (R11) (R4)
            state_reg <= ST_IDLE;
         end
         else
         begin
            if (tick)
               act_reg <= ~act_reg;
            if (cap_ev)
            begin
               sr_reg  <= {sr_reg[6:0], link.dev_sdi};                 // (R1) (R3)
               cnt_reg <= cnt_aft;
            end
            if (lau_ev)
               sdo_reg <= sr_reg[7];                                   // (R2)
            if (finish)
            begin
               cnt_reg   <= 4'h0;
               state_reg <= ST_DONE;
            end
         end
      end
   end
endmodule : sync_serial_port
